/* File: design/tpg_map.svh */
// Register offsets, field positions, reset values and counts of the test pattern generator.
// Assumes inclusion by bare name from the design files.
`ifndef TPG_MAP_SVH
`define TPG_MAP_SVH

// ****************************************
// Register word indexes
// ****************************************
`define TPG_ADDR_CTRL      4'h0
`define TPG_ADDR_FILL      4'h1
`define TPG_ADDR_GAIN      4'h2
`define TPG_ADDR_OFFSET    4'h3
`define TPG_ADDR_STATUS    4'h4

// ****************************************
// Field positions
// ****************************************
`define TPG_CTRL_MODE_LSB  0
`define TPG_CTRL_MODE_MSB  2
`define TPG_CTRL_FFC_BIT   3
`define TPG_CTRL_SAVE_BIT  4
`define TPG_CTRL_CLRB_BIT  5
`define TPG_STAT_ACT_BIT   0
`define TPG_STAT_BOOT_BIT  1
`define TPG_STAT_PERS_BIT  2
`define TPG_STAT_LVL_LSB   16

// ****************************************
// Reset values and counts
// ****************************************
`define TPG_GAIN_UNITY     16'h0100
`define TPG_OFFSET_ZERO    12'h000
`define TPG_FILL_RESET     12'h000
`define TPG_PIX_MAX        12'hFFF
`define TPG_RAMP_PERIOD    4096
`define TPG_NU_H_PERIOD    64
`define TPG_NU_V_PERIOD    62

`endif

/* File: design/tpg_pkg.sv */
// Types shared by the test pattern generator files.
// Assumes nothing of its surroundings.
package tpg_pkg;
   typedef enum logic [2:0] {
      TPG_OFF     = 3'h0,
      TPG_HRAMP   = 3'h1,
      TPG_VRAMP   = 3'h2,
      TPG_UNIFORM = 3'h3,
      TPG_DIAG    = 3'h4,
      TPG_FILL    = 3'h5,
      TPG_NONUNI  = 3'h6
   } tpg_mode_t;
endpackage

/* File: design/tpg_ramp_if.sv */
// Carrier between the generator and one ramp counter.
// Assumes one owner and one user per instance.
`timescale 1ns/1ps
`default_nettype none
interface tpg_ramp_if;
   logic        step;
   logic        restart;
   logic        clear;
   logic [11:0] value;
   modport owner (input step, input restart, input clear, output value);
   modport user  (output step, output restart, output clear, input value);
endinterface
`default_nettype wire

/* File: design/tpg_ramp.sv */
// One wrapping ramp counter of a given period.
// Assumes step, restart and clear are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tpg_ramp #(
   parameter int PERIOD = 4096
) (
   input  wire logic   sys_clk,
   input  wire logic   reset,
   tpg_ramp_if.owner   r
);
   localparam logic [11:0] LAST = 12'(PERIOD - 1);

   logic [11:0] val_reg;
   logic [11:0] val_next;

   // Restart makes the current position zero
   assign r.value = r.restart ? 12'h000 : val_reg;

   always_comb begin
      val_next = r.value;
      if (r.clear) begin
         val_next = 12'h000;
      end else if (r.step) begin
         val_next = (r.value == LAST) ? 12'h000 : r.value + 12'h001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         val_reg <= 12'h000;
      end else begin
         val_reg <= val_next;
      end
   end

   a_ramp_wrap: assert property (@(posedge sys_clk) disable iff (reset)
      (r.step && !r.clear && r.value == LAST) |=> val_reg == 12'h000)
      else $error("ramp did not wrap at period end");
endmodule
`default_nettype wire

/* File: design/tpg_top.sv */
// Test pattern generator: replaces sensor pixels by synthetic patterns.
// Assumes a pixel stream with start-of-frame and end-of-line marks on sys_clk.
//
// Contract
// - Horizontal ramp repeats every 4096 columns
// - Vertical ramp repeats every 4096 lines
// - Uniform frame level rises one count per frame
// - Diagonal equals horizontal plus vertical ramp
// - Fill mode drives the static fill value
// - Twice sum of 64/62 ramps plus fill
// - Pattern forces unity gain, zero offset, no correction
// - Save settings on entry, restore on exit
// - Saved pattern disables processing after restart
//
// Local design decisions: the address-and-strobe port and the register offsets.
`include "tpg_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tpg_top (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        in_valid,
   input  wire logic        in_sof,
   input  wire logic        in_eol,
   input  wire logic [11:0] in_data,
   output logic             out_valid,
   output logic             out_sof,
   output logic             out_eol,
   output logic      [11:0] out_data,
   input  wire logic        boot_pattern_flag,
   output logic             persist_pattern_flag,
   output logic      [15:0] gain_out,
   output logic      [11:0] offset_out,
   output logic             ffc_en_out
);
   // ****************************************
   // Registers
   // ****************************************
   tpg_pkg::tpg_mode_t mode_reg;
   logic [11:0]        fill_reg;
   logic [15:0]        gain_reg;
   logic [11:0]        offset_reg;
   logic               ffc_reg;
   logic [15:0]        saved_gain_reg;
   logic [11:0]        saved_offset_reg;
   logic               saved_ffc_reg;
   logic               active_d_reg;
   logic               boot_done_reg;
   logic               boot_disable_reg;
   logic [11:0]        frame_next_reg;
   logic [11:0]        frame_level_reg;
   logic               pattern_active;
   logic               forced;
   logic               wr_ctrl;
   logic               enter_pat;
   logic               leave_pat;

   assign pattern_active = (mode_reg != tpg_pkg::TPG_OFF);
   assign forced         = pattern_active | boot_disable_reg;
   assign wr_ctrl        = reg_wr && (reg_addr == `TPG_ADDR_CTRL);
   assign enter_pat      = pattern_active && !active_d_reg;
   assign leave_pat      = !pattern_active && active_d_reg;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mode_reg <= tpg_pkg::TPG_OFF;
      end else if (wr_ctrl &&
                   reg_wdata[`TPG_CTRL_MODE_MSB:`TPG_CTRL_MODE_LSB] <= 3'h6) begin
         mode_reg <= tpg_pkg::tpg_mode_t'(reg_wdata[`TPG_CTRL_MODE_MSB:`TPG_CTRL_MODE_LSB]);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         fill_reg <= `TPG_FILL_RESET;
      end else if (reg_wr && reg_addr == `TPG_ADDR_FILL) begin
         fill_reg <= reg_wdata[11:0];
      end
   end

   // Working video settings; restore on exit overrides any write
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gain_reg   <= `TPG_GAIN_UNITY;
         offset_reg <= `TPG_OFFSET_ZERO;
         ffc_reg    <= 1'b0;
      end else if (leave_pat) begin
         gain_reg   <= saved_gain_reg;
         offset_reg <= saved_offset_reg;
         ffc_reg    <= saved_ffc_reg;
      end else begin
         if (reg_wr && reg_addr == `TPG_ADDR_GAIN) begin
            gain_reg <= reg_wdata[15:0];
         end
         if (reg_wr && reg_addr == `TPG_ADDR_OFFSET) begin
            offset_reg <= reg_wdata[11:0];
         end
         if (wr_ctrl) begin
            ffc_reg <= reg_wdata[`TPG_CTRL_FFC_BIT];
         end
      end
   end

   // Snapshot of video settings on entering a pattern
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         active_d_reg     <= 1'b0;
         saved_gain_reg   <= `TPG_GAIN_UNITY;
         saved_offset_reg <= `TPG_OFFSET_ZERO;
         saved_ffc_reg    <= 1'b0;
      end else begin
         active_d_reg <= pattern_active;
         if (enter_pat) begin
            saved_gain_reg   <= gain_reg;
            saved_offset_reg <= offset_reg;
            saved_ffc_reg    <= ffc_reg;
         end
      end
   end

   // Flag catch after reset release and pattern state for saving
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         boot_done_reg        <= 1'b0;
         boot_disable_reg     <= 1'b0;
         persist_pattern_flag <= 1'b0;
      end else begin
         boot_done_reg <= 1'b1;
         if (!boot_done_reg) begin
            boot_disable_reg <= boot_pattern_flag;
         end else if (wr_ctrl && reg_wdata[`TPG_CTRL_CLRB_BIT]) begin
            boot_disable_reg <= 1'b0;
         end
         if (wr_ctrl && reg_wdata[`TPG_CTRL_SAVE_BIT]) begin
            persist_pattern_flag <= pattern_active;
         end
      end
   end

   // Processing stages forced neutral during a pattern
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gain_out   <= `TPG_GAIN_UNITY;
         offset_out <= `TPG_OFFSET_ZERO;
         ffc_en_out <= 1'b0;
      end else begin
         gain_out   <= forced ? `TPG_GAIN_UNITY : gain_reg;
         offset_out <= forced ? `TPG_OFFSET_ZERO : offset_reg;
         ffc_en_out <= forced ? 1'b0 : ffc_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `TPG_ADDR_CTRL:   reg_rdata <= {28'h0000000, ffc_reg, mode_reg};
            `TPG_ADDR_FILL:   reg_rdata <= {20'h00000, fill_reg};
            `TPG_ADDR_GAIN:   reg_rdata <= {16'h0000, gain_reg};
            `TPG_ADDR_OFFSET: reg_rdata <= {20'h00000, offset_reg};
            `TPG_ADDR_STATUS: reg_rdata <= {4'h0, frame_level_reg, 13'h0000,
                                            persist_pattern_flag, boot_disable_reg,
                                            pattern_active};
            default:          reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // ****************************************
   // Pattern generation
   // ****************************************
   tpg_ramp_if h_if ();
   tpg_ramp_if v_if ();
   tpg_ramp_if hn_if ();
   tpg_ramp_if vn_if ();

   assign h_if.step     = in_valid;
   assign h_if.restart  = in_valid && in_sof;
   assign h_if.clear    = in_valid && in_eol;
   assign hn_if.step    = in_valid;
   assign hn_if.restart = in_valid && in_sof;
   assign hn_if.clear   = in_valid && in_eol;
   assign v_if.step     = in_valid && in_eol;
   assign v_if.restart  = in_valid && in_sof;
   assign v_if.clear    = 1'b0;
   assign vn_if.step    = in_valid && in_eol;
   assign vn_if.restart = in_valid && in_sof;
   assign vn_if.clear   = 1'b0;

   tpg_ramp #(.PERIOD(`TPG_RAMP_PERIOD)) u_h  (.sys_clk(sys_clk), .reset(reset), .r(h_if));
   tpg_ramp #(.PERIOD(`TPG_RAMP_PERIOD)) u_v  (.sys_clk(sys_clk), .reset(reset), .r(v_if));
   tpg_ramp #(.PERIOD(`TPG_NU_H_PERIOD)) u_hn (.sys_clk(sys_clk), .reset(reset), .r(hn_if));
   tpg_ramp #(.PERIOD(`TPG_NU_V_PERIOD)) u_vn (.sys_clk(sys_clk), .reset(reset), .r(vn_if));

   // Frame level latched at each frame start
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         frame_next_reg  <= 12'h000;
         frame_level_reg <= 12'h000;
      end else if (in_valid && in_sof) begin
         frame_level_reg <= frame_next_reg;
         frame_next_reg  <= frame_next_reg + 12'h001;
      end
   end

   function automatic logic [11:0] clip(input logic [13:0] s);
      return (s > 14'(`TPG_PIX_MAX)) ? `TPG_PIX_MAX : s[11:0];
   endfunction

   logic [11:0] level_cur;
   logic [13:0] diag_sum;
   logic [13:0] nu_sum;
   logic [13:0] nu_pair;
   logic [11:0] gen_pix;

   assign level_cur = in_sof ? frame_next_reg : frame_level_reg;
   assign diag_sum  = {2'b00, h_if.value} + {2'b00, v_if.value};
   assign nu_pair   = {2'b00, hn_if.value} + {2'b00, vn_if.value};
   assign nu_sum    = {nu_pair[12:0], 1'b0} + {2'b00, fill_reg};

   always_comb begin
      case (mode_reg)
         tpg_pkg::TPG_HRAMP:   gen_pix = h_if.value;
         tpg_pkg::TPG_VRAMP:   gen_pix = v_if.value;
         tpg_pkg::TPG_UNIFORM: gen_pix = level_cur;
         tpg_pkg::TPG_DIAG:    gen_pix = clip(diag_sum);
         tpg_pkg::TPG_FILL:    gen_pix = fill_reg;
         tpg_pkg::TPG_NONUNI:  gen_pix = clip(nu_sum);
         default:              gen_pix = in_data;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         out_valid <= 1'b0;
         out_sof   <= 1'b0;
         out_eol   <= 1'b0;
         out_data  <= 12'h000;
      end else begin
         out_valid <= in_valid;
         out_sof   <= in_valid && in_sof;
         out_eol   <= in_valid && in_eol;
         if (in_valid) begin
            out_data <= gen_pix;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_hramp_step: assert property (in_valid && !in_eol && h_if.value != `TPG_PIX_MAX
      |=> (in_valid && in_sof) || h_if.value == $past(h_if.value) + 12'h001)
      else $error("horizontal ramp did not advance");
   a_vramp_step: assert property (in_valid && in_eol && v_if.value != `TPG_PIX_MAX
      |=> (in_valid && in_sof) || v_if.value == $past(v_if.value) + 12'h001)
      else $error("vertical ramp did not advance per line");
   a_uniform_level: assert property (in_valid && !in_sof && mode_reg == tpg_pkg::TPG_UNIFORM
      |=> out_data == $past(frame_level_reg))
      else $error("uniform pixel differs from frame level");
   a_uniform_frame: assert property (in_valid && in_sof && frame_next_reg != 12'h000
      |=> frame_level_reg == $past(frame_level_reg) + 12'h001)
      else $error("frame level did not step by one");
   a_diag_sum: assert property (in_valid && mode_reg == tpg_pkg::TPG_DIAG
      |=> out_data == clip($past(diag_sum)))
      else $error("diagonal pixel is not the ramp sum");
   a_fill_value: assert property (in_valid && mode_reg == tpg_pkg::TPG_FILL
      |=> out_data == $past(fill_reg))
      else $error("fill pixel differs from fill value");
   a_nonuni_pix: assert property (in_valid && mode_reg == tpg_pkg::TPG_NONUNI
      |=> out_data == clip(14'(2 * ($past(hn_if.value) + $past(vn_if.value)) + $past(fill_reg))))
      else $error("non-uniformity pixel wrong");
   a_force_neutral: assert property (pattern_active ##1 pattern_active
      |-> gain_out == `TPG_GAIN_UNITY && offset_out == `TPG_OFFSET_ZERO && !ffc_en_out)
      else $error("processing not neutral during pattern");
   a_restore_set: assert property (leave_pat |=> gain_reg == $past(saved_gain_reg)
      && ffc_reg == $past(saved_ffc_reg) ##1 ffc_en_out == $past(ffc_reg))
      else $error("video settings not restored");
   a_boot_disable: assert property (boot_disable_reg |=> !ffc_en_out
      && gain_out == `TPG_GAIN_UNITY)
      else $error("processing active after pattern restart");

   c_enter_pat: cover property (enter_pat ##[1:50] leave_pat);
   c_diag_clip: cover property (in_valid && mode_reg == tpg_pkg::TPG_DIAG && diag_sum > 14'h0FFF);
   c_nonuni_run: cover property (in_valid && mode_reg == tpg_pkg::TPG_NONUNI && in_eol);
   c_boot_flag: cover property (boot_disable_reg ##1 !boot_disable_reg);
endmodule
`default_nettype wire

/* File: verification/tpg_sink.sv */
// Downstream pixel pipeline model: takes every output pixel and counts pixels and frames.
// Assumes the generator's registered output stream on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tpg_sink (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        out_valid,
   input  wire logic        out_sof,
   input  wire logic [11:0] out_data,
   output int               pixels,
   output int               frames,
   output logic      [11:0] last_data
);
   // ****************************************
   // Always ready, never stalls the stream
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pixels    <= 0;
         frames    <= 0;
         last_data <= 12'h000;
      end else if (out_valid) begin
         pixels    <= pixels + 1;
         frames    <= frames + (out_sof ? 1 : 0);
         last_data <= out_data;
      end
   end
endmodule
`default_nettype wire

/* File: verification/tpg_top_bench.sv */
// Self-checking bench of the test pattern generator with a downstream sink model.
// Assumes the register map header and the mode type of the design package.
`include "tpg_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tpg_top_bench;
   logic               sys_clk, reset, reg_wr, reg_rd, in_valid, in_sof, in_eol;
   logic        [3:0]  reg_addr;
   logic        [31:0] reg_wdata, reg_rdata;
   logic        [11:0] in_data, out_data, offset_out, last_data;
   logic        [15:0] gain_out;
   logic               out_valid, out_sof, out_eol, boot_pattern_flag;
   logic               persist_pattern_flag, ffc_en_out;
   int                 err_total, compares, sofs, sent, pixels, frames, fill_v;
   tpg_pkg::tpg_mode_t cur_mode;

   tpg_top uut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
      .in_sof(in_sof), .in_eol(in_eol), .in_data(in_data), .out_valid(out_valid),
      .out_sof(out_sof), .out_eol(out_eol), .out_data(out_data),
      .boot_pattern_flag(boot_pattern_flag), .persist_pattern_flag(persist_pattern_flag),
      .gain_out(gain_out), .offset_out(offset_out), .ffc_en_out(ffc_en_out));
   tpg_sink sink (.sys_clk(sys_clk), .reset(reset), .out_valid(out_valid), .out_sof(out_sof),
      .out_data(out_data), .pixels(pixels), .frames(frames), .last_data(last_data));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic results();
      $display("mismatches %0d of %0d compares", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk(reg_rdata & m, e);
   endtask
   // Mode changes only between frames, stream idle
   task automatic ctrl(input logic [31:0] d);
      wr(`TPG_ADDR_CTRL, d);
      if (d[2:0] != 3'h7) cur_mode = tpg_pkg::tpg_mode_t'(d[2:0]);
   endtask
   task automatic settle(input logic [15:0] g, input logic [11:0] o, input logic f);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({3'h0, gain_out, offset_out, ffc_en_out}, {3'h0, g, o, f});
   endtask
   function automatic logic [11:0] expv(input int h, input int v);
      int s;
      case (cur_mode)
         tpg_pkg::TPG_HRAMP:   s = h % 4096;
         tpg_pkg::TPG_VRAMP:   s = v % 4096;
         tpg_pkg::TPG_UNIFORM: s = (sofs - 1) % 4096;
         tpg_pkg::TPG_DIAG:    s = h + v;
         tpg_pkg::TPG_FILL:    s = fill_v;
         tpg_pkg::TPG_NONUNI:  s = 2 * (h % 64 + v % 62) + fill_v;
         default:              s = 'h5A5;
      endcase
      if (s > 4095) s = 4095;
      return s[11:0];
   endfunction
   task automatic px(input logic s, input logic e, input logic [11:0] x);
      @(posedge sys_clk);
      in_valid <= 1'b1;
      in_sof <= s;
      in_eol <= e;
      in_data <= 12'h5A5;
      @(posedge sys_clk);
      in_valid <= 1'b0;
      in_sof <= 1'b0;
      in_eol <= 1'b0;
      sent++;
      @(negedge sys_clk);
      chk({out_valid, out_sof, out_eol, out_data}, {1'b1, s, e, x});
   endtask
   task automatic frame(input int lines, input int cols);
      sofs++;
      for (int v = 0; v < lines; v++)
         for (int h = 0; h < cols; h++)
            px(h == 0 && v == 0, h == cols - 1, expv(h, v));
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic sc_regs();
      settle(`TPG_GAIN_UNITY, 12'h000, 1'b0);
      rd(`TPG_ADDR_GAIN, 32'h0000_0100, 32'hFFFF_FFFF);
      wr(4'h9, 32'h0000_0777);
      rd(4'h9, 32'h0000_0000, 32'hFFFF_FFFF);
      rd(`TPG_ADDR_FILL, 32'h0000_0000, 32'hFFFF_FFFF);
   endtask
   task automatic sc_force();
      wr(`TPG_ADDR_GAIN, 32'h0000_0200);
      wr(`TPG_ADDR_OFFSET, 32'h0000_0010);
      ctrl(32'h0000_0008);
      settle(16'h0200, 12'h010, 1'b1);
      ctrl(32'h0000_0009);
      settle(`TPG_GAIN_UNITY, 12'h000, 1'b0);
      rd(`TPG_ADDR_CTRL, 32'h0000_0009, 32'hFFFF_FFFF);
      rd(`TPG_ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
      wr(`TPG_ADDR_GAIN, 32'h0000_0300);
      settle(`TPG_GAIN_UNITY, 12'h000, 1'b0);
   endtask
   task automatic sc_patterns();
      frame(1, 4098);
      ctrl(32'h0000_000A);
      frame(4098, 1);
      ctrl(32'h0000_000C);
      frame(2, 4096);
      fill_v = 'h123;
      wr(`TPG_ADDR_FILL, 32'h0000_0123);
      ctrl(32'h0000_000D);
      ctrl(32'h0000_000F);
      rd(`TPG_ADDR_CTRL, 32'h0000_000D, 32'hFFFF_FFFF);
      frame(2, 3);
      ctrl(32'h0000_000E);
      frame(63, 66);
      fill_v = 'hFFE;
      wr(`TPG_ADDR_FILL, 32'h0000_0FFE);
      frame(1, 2);
      ctrl(32'h0000_000B);
      repeat (3) frame(1, 2);
      rd(`TPG_ADDR_STATUS, 32'h0008_0001, 32'h0FFF_0001);
   endtask
   task automatic sc_restore();
      ctrl(32'h0000_0019);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({31'h0, persist_pattern_flag}, 32'h0000_0001);
      ctrl(32'h0000_0008);
      settle(16'h0200, 12'h010, 1'b1);
      rd(`TPG_ADDR_STATUS, 32'h0000_0004, 32'h0000_0005);
      frame(1, 2);
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(pixels, sent);
      chk(frames, sofs);
      chk({20'h00000, last_data}, 32'h0000_05A5);
   endtask
   task automatic sc_boot();
      @(posedge sys_clk);
      boot_pattern_flag <= 1'b1;
      reset <= 1'b1;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      ctrl(32'h0000_0008);
      settle(`TPG_GAIN_UNITY, 12'h000, 1'b0);
      rd(`TPG_ADDR_STATUS, 32'h0000_0002, 32'h0000_0007);
      ctrl(32'h0000_0028);
      settle(`TPG_GAIN_UNITY, 12'h000, 1'b1);
   endtask

   // ****************************************
   // Clock, reset and main sequence
   // ****************************************
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (100000) @(posedge sys_clk);
      err_total++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
   end
   initial begin
      reset = 1'b1;
      {reg_wr, reg_rd, in_valid, in_sof, in_eol, boot_pattern_flag} = 6'h00;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      in_data = 12'h000;
      err_total = 0;
      compares = 0;
      sofs = 0;
      sent = 0;
      fill_v = 0;
      cur_mode = tpg_pkg::TPG_OFF;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      sc_regs();
      sc_force();
      sc_patterns();
      sc_restore();
      sc_boot();
      results();
   end
endmodule
`default_nettype wire
